// >>> pmcm_defs.svh
// constants for the power-mode and clock-source manager
// assumes a 20 MHz core clock (50 ns period)
`ifndef PMCM_DEFS_SVH
`define PMCM_DEFS_SVH
`define PMCM_CLK_HZ        20000000
`define PMCM_SLOW_HZ       32768
// wishbone word offsets (byte addresses)
`define PMCM_A_CTRL        8'h00
`define PMCM_A_STATUS      8'h04
`define PMCM_A_IRQ_STAT    8'h08
`define PMCM_A_IRQ_CLR     8'h0c
`define PMCM_A_IRQ_EN      8'h10
`define PMCM_A_SLEEP_LEN   8'h14
`define PMCM_A_FREQ        8'h18
`define PMCM_A_METER       8'h1c
// ctrl fields
`define PMCM_C_GO_ACTIVE   0
`define PMCM_C_GO_IDLE     1
`define PMCM_C_GO_SLEEP    2
`define PMCM_C_EXT_CLK     3
// irq bits
`define PMCM_I_STATE       0
`define PMCM_I_WAKE        1
`define PMCM_I_FREQ        2
`define PMCM_NIRQ          3
// detect window: core cycles before giving up on an rtc, and slow edges that accept one
`define PMCM_DET_CYC       16'hffff
`define PMCM_DET_EDGES     4'h4
// meter window in slow periods
`define PMCM_METER_PER     16
// frequency codes, classified from counts over 16 slow periods
`define PMCM_F_19M2        3'h0
`define PMCM_F_20M         3'h1
`define PMCM_F_24M         3'h2
`define PMCM_F_26M         3'h3
`define PMCM_F_38M4        3'h4
`define PMCM_F_40M         3'h5
`define PMCM_F_52M         3'h6
`define PMCM_SLEEP_RST     32'h0000_8000
`endif

// >>> pmcm_pkg.sv
// types for the power-mode and clock-source manager
package pmcm_pkg;
  typedef enum logic [2:0] {
    PMCM_OFF     = 3'b000,
    PMCM_STANDBY = 3'b001,
    PMCM_ACTIVE  = 3'b011,
    PMCM_IDLE    = 3'b010,
    PMCM_SLEEP   = 3'b110
  } pmcm_state_e;
  typedef enum logic [1:0] {
    PMCM_SRC_NONE = 2'h0,
    PMCM_SRC_RTC  = 2'h1,
    PMCM_SRC_DIV  = 2'h2
  } pmcm_src_e;
endpackage

// >>> pmcm_slow_div.sv
// rf crystal divider producing the divided slow clock enable
// assumes the crystal clock is the core clock; fractional accumulator
`timescale 1ns/1ps
module pmcm_slow_div
  import pmcm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        run,
  input  wire logic [23:0] step,
  // output
  output logic             tick
);
  logic [23:0] acc_q;
  logic [24:0] sum;

  // phase accumulator: tick each time the sum wraps
  assign sum = {1'b0, acc_q} + {1'b0, step};

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      acc_q <= 24'h00_0000;
      tick  <= 1'b0;
    end else begin
      acc_q <= sum[23:0];
      tick  <= sum[24];
    end
  end
endmodule

// >>> pmcm_top.sv
// power-mode and clock-source manager with wishbone registers
// assumes CORE_CLK is the rf crystal clock at 20 MHz and RTC_CLK_IN is
// sampled synchronously; gate outputs drive clock-gate cells elsewhere
`timescale 1ns/1ps
`include "pmcm_defs.svh"

module pmcm_top
  import pmcm_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // supply and wake
  input  wire logic        SUPPLY_OK,
  input  wire logic        SUPPLY_ENABLE_PIN,
  input  wire logic        HOST_WAKE,
  input  wire logic        HW_TRIGGER,
  input  wire logic        BB_SLEEP_REQ,
  input  wire logic        RTC_CLK_IN,
  // gates and status
  output logic             SLOW_CLK_EN,
  output logic             PLL_EN,
  output logic             CPU_CLK_EN,
  output logic             CPU_CLK_SEL_PLL,
  output logic             BUS_CLK_EN,
  output logic             XTAL_EN,
  output logic             XTAL_EXT_SEL,
  output logic             SLOW_FROM_DIV,
  output logic             SLOW_SLEEP_CLOCK,
  output logic             IRQ
);
  pmcm_state_e st_q, st_d;
  pmcm_src_e   src_q;
  logic        pwr_ok, go_active_q, go_idle_q, ext_clk_q, pll_ready_q;
  logic [31:0] sleep_len_q, sleep_cnt_q;
  logic [2:0]  freq_q;
  logic        freq_valid_q;
  logic [15:0] det_cnt_q;
  logic [3:0]  det_edges_q;
  logic        rtc_d1_q, rtc_d2_q, rtc_d3_q, slow_edge, div_tick;
  logic        slow_lvl_q, wake_d_q, wake_edge;
  logic [3:0]  mper_q;
  logic [15:0] mcnt_q, meter_q;
  logic [`PMCM_NIRQ-1:0] ist_q, ien_q, iev;
  logic        wb_req, wb_wr;
  logic [23:0] div_step;

  assign pwr_ok    = SUPPLY_OK && SUPPLY_ENABLE_PIN;
  assign wb_req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr     = wb_req && WB_WE_I && WB_SEL_I[0];
  assign slow_edge = (src_q == PMCM_SRC_RTC) ? (rtc_d2_q && !rtc_d3_q)
                                             : div_tick;
  assign wake_edge = HOST_WAKE && !wake_d_q;

  // rtc input: plain sampling, then an edge detector behind two stages
  always_ff @(posedge CORE_CLK) begin
    rtc_d1_q <= RTC_CLK_IN;
    rtc_d2_q <= rtc_d1_q;
    rtc_d3_q <= rtc_d2_q;
    wake_d_q <= HOST_WAKE;
  end

  // step for 2^24 * 32768 / 20e6, the divider's fixed crystal rate
  assign div_step = 24'(((64'd1 << 24) * `PMCM_SLOW_HZ) / `PMCM_CLK_HZ);

  pmcm_slow_div u_div (
    .clk  (CORE_CLK),
    .rst  (RESET),
    .run  (src_q == PMCM_SRC_DIV),
    .step (div_step),
    .tick (div_tick)
  );

  // probe for an rtc during power-on
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !pwr_ok) begin
      src_q       <= PMCM_SRC_NONE;
      det_cnt_q   <= 16'h0000;
      det_edges_q <= 4'h0;
    end else if (src_q == PMCM_SRC_NONE) begin
      det_cnt_q <= det_cnt_q + 16'h0001;
      if (rtc_d2_q && !rtc_d3_q)
        det_edges_q <= det_edges_q + 4'h1;
      if (det_edges_q == `PMCM_DET_EDGES)
        src_q <= PMCM_SRC_RTC;
      else if (det_cnt_q == `PMCM_DET_CYC)
        src_q <= PMCM_SRC_DIV;
    end
  end

  // slow clock level toggles on each slow edge
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !pwr_ok || st_q == PMCM_OFF)
      slow_lvl_q <= 1'b0;
    else if (slow_edge)
      slow_lvl_q <= !slow_lvl_q;
  end

  // frequency meter: crystal cycles over 16 slow periods
  always_ff @(posedge CORE_CLK) begin
    if (RESET || src_q != PMCM_SRC_RTC) begin
      mper_q  <= 4'h0;
      mcnt_q  <= 16'h0000;
      meter_q <= 16'h0000;
    end else if (rtc_d2_q && !rtc_d3_q) begin
      mper_q <= mper_q + 4'h1;
      if (mper_q == 4'(`PMCM_METER_PER - 1)) begin
        meter_q <= mcnt_q;
        mcnt_q  <= 16'h0000;
      end else
        mcnt_q <= mcnt_q + 16'h0001;
    end else
      mcnt_q <= mcnt_q + 16'h0001;
  end

  // classify metered count; nearest band midpoints in 16-period cycles
  function automatic logic [2:0] classify(input logic [15:0] c);
    if (c < 16'h2562)      classify = `PMCM_F_19M2;
    else if (c < 16'h29f6) classify = `PMCM_F_20M;
    else if (c < 16'h2fae) classify = `PMCM_F_24M;
    else if (c < 16'h3d6a) classify = `PMCM_F_26M;
    else if (c < 16'h4ac4) classify = `PMCM_F_38M4;
    else if (c < 16'h57bd) classify = `PMCM_F_40M;
    else                   classify = `PMCM_F_52M;
  endfunction

  // frequency code: metered with rtc, software-written otherwise
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      freq_q       <= `PMCM_F_26M;
      freq_valid_q <= 1'b0;
    end else if (src_q == PMCM_SRC_RTC && meter_q != 16'h0000) begin
      freq_q       <= classify(meter_q);
      freq_valid_q <= 1'b1;
    end else if (src_q != PMCM_SRC_RTC && wb_wr &&
                 WB_ADR_I == `PMCM_A_FREQ) begin
      freq_q       <= WB_DAT_I[2:0];
      freq_valid_q <= 1'b1;
    end
  end

  // control register; go bits self-clear when consumed
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      go_active_q <= 1'b0;
      go_idle_q   <= 1'b0;
      ext_clk_q   <= 1'b0;
      sleep_len_q <= `PMCM_SLEEP_RST;
      ien_q       <= '0;
    end else begin
      if (wb_wr && WB_ADR_I == `PMCM_A_CTRL) begin
        go_active_q <= WB_DAT_I[`PMCM_C_GO_ACTIVE];
        go_idle_q   <= WB_DAT_I[`PMCM_C_GO_IDLE];
        ext_clk_q   <= WB_DAT_I[`PMCM_C_EXT_CLK];
      end else begin
        if (st_q != PMCM_STANDBY) go_active_q <= 1'b0;
        if (st_q != PMCM_ACTIVE)  go_idle_q   <= 1'b0;
      end
      if (wb_wr && WB_ADR_I == `PMCM_A_SLEEP_LEN)
        sleep_len_q <= WB_DAT_I;
      if (wb_wr && WB_ADR_I == `PMCM_A_IRQ_EN)
        ien_q <= WB_DAT_I[`PMCM_NIRQ-1:0];
    end
  end

  // state machine
  always_comb begin
    st_d = st_q;
    case (st_q)
      PMCM_OFF:     st_d = PMCM_STANDBY;
      PMCM_STANDBY: if (go_active_q) st_d = PMCM_ACTIVE;
      PMCM_ACTIVE: begin
        if (BB_SLEEP_REQ)   st_d = PMCM_SLEEP;
        else if (go_idle_q) st_d = PMCM_IDLE;
      end
      PMCM_IDLE: begin
        if (BB_SLEEP_REQ)    st_d = PMCM_SLEEP;
        else if (HW_TRIGGER) st_d = PMCM_ACTIVE;
      end
      PMCM_SLEEP: begin
        if (wake_edge || (slow_edge && sleep_cnt_q == 32'h0000_0000))
          st_d = PMCM_STANDBY;
      end
      default: st_d = PMCM_OFF;
    endcase
    if (!pwr_ok) st_d = PMCM_OFF;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) st_q <= PMCM_OFF;
    else       st_q <= st_d;
  end

  // sleep interval counted in slow periods
  always_ff @(posedge CORE_CLK) begin
    if (RESET || st_q != PMCM_SLEEP)
      sleep_cnt_q <= sleep_len_q;
    else if (slow_edge && sleep_cnt_q != 32'h0000_0000)
      sleep_cnt_q <= sleep_cnt_q - 32'h0000_0001;
  end

  // pll must run one cycle before the cpu is switched onto it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) pll_ready_q <= 1'b0;
    else       pll_ready_q <= (st_q == PMCM_ACTIVE);
  end

  // clock gates per state, all registered
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      SLOW_CLK_EN     <= 1'b0;
      PLL_EN          <= 1'b0;
      CPU_CLK_EN      <= 1'b0;
      CPU_CLK_SEL_PLL <= 1'b0;
      BUS_CLK_EN      <= 1'b0;
      XTAL_EN         <= 1'b0;
    end else begin
      SLOW_CLK_EN     <= st_q != PMCM_OFF;
      PLL_EN          <= st_q == PMCM_ACTIVE;
      CPU_CLK_EN      <= st_q == PMCM_STANDBY ||
                         (st_q == PMCM_ACTIVE && pll_ready_q);
      CPU_CLK_SEL_PLL <= st_q == PMCM_ACTIVE && pll_ready_q;
      BUS_CLK_EN      <= st_q == PMCM_STANDBY || st_q == PMCM_ACTIVE ||
                         st_q == PMCM_IDLE;
      XTAL_EN         <= st_q == PMCM_STANDBY || st_q == PMCM_ACTIVE ||
                         st_q == PMCM_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      XTAL_EXT_SEL     <= 1'b0;
      SLOW_FROM_DIV    <= 1'b0;
      SLOW_SLEEP_CLOCK <= 1'b0;
    end else begin
      XTAL_EXT_SEL     <= ext_clk_q;
      SLOW_FROM_DIV    <= src_q == PMCM_SRC_DIV;
      SLOW_SLEEP_CLOCK <= slow_lvl_q;
    end
  end

  // interrupts: set wins over a clear in the same cycle
  assign iev[`PMCM_I_STATE] = st_d != st_q;
  assign iev[`PMCM_I_WAKE]  = st_q == PMCM_SLEEP && st_d == PMCM_STANDBY;
  assign iev[`PMCM_I_FREQ]  = src_q == PMCM_SRC_RTC && !freq_valid_q &&
                              meter_q != 16'h0000;

  always_ff @(posedge CORE_CLK) begin
    if (RESET)
      ist_q <= '0;
    else if (wb_wr && WB_ADR_I == `PMCM_A_IRQ_CLR)
      ist_q <= (ist_q & ~WB_DAT_I[`PMCM_NIRQ-1:0]) | iev;
    else
      ist_q <= ist_q | iev;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) IRQ <= 1'b0;
    else       IRQ <= |(ist_q & ien_q);
  end

  // wishbone: ack one cycle after request, unmapped reads as zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          `PMCM_A_CTRL:      WB_DAT_O <= {28'h0, ext_clk_q, 1'b0,
                                          go_idle_q, go_active_q};
          `PMCM_A_STATUS:    WB_DAT_O <= {24'h0, 1'b0, SLOW_FROM_DIV,
                                          src_q, 1'b0, st_q};
          `PMCM_A_IRQ_STAT:  WB_DAT_O <= {29'h0, ist_q};
          `PMCM_A_IRQ_EN:    WB_DAT_O <= {29'h0, ien_q};
          `PMCM_A_SLEEP_LEN: WB_DAT_O <= sleep_len_q;
          `PMCM_A_FREQ:      WB_DAT_O <= {27'h0, freq_valid_q, 1'b0,
                                          freq_q};
          `PMCM_A_METER:     WB_DAT_O <= {16'h0, meter_q};
          default:           WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// >>> pmcm_top_asserts.sv
// port checker for pmcm_top, bound into every instance
// assumes one CORE_CLK domain and synchronous RESET
`timescale 1ns/1ps
module pmcm_chk (
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  // bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // supply and wake
  input wire logic        SUPPLY_OK,
  input wire logic        SUPPLY_ENABLE_PIN,
  input wire logic        HOST_WAKE,
  input wire logic        HW_TRIGGER,
  input wire logic        BB_SLEEP_REQ,
  // gates
  input wire logic        SLOW_CLK_EN,
  input wire logic        PLL_EN,
  input wire logic        CPU_CLK_EN,
  input wire logic        CPU_CLK_SEL_PLL,
  input wire logic        BUS_CLK_EN,
  input wire logic        XTAL_EN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // state lands one edge late, gates one more
  property p_off;
    !(SUPPLY_OK && SUPPLY_ENABLE_PIN) |-> ##2
      !(SLOW_CLK_EN || PLL_EN || CPU_CLK_EN || BUS_CLK_EN || XTAL_EN);
  endproperty
  a_off: assert property (p_off) else $error("gate on while off");
  property p_ack;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("no bus ack");
  property p_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_dat;
    !WB_ACK_O |-> WB_DAT_O == 32'h0;
  endproperty
  a_dat: assert property (p_dat) else $error("data without ack");
  property p_pll_first;
    $rose(CPU_CLK_SEL_PLL) |-> $past(PLL_EN) && PLL_EN;
  endproperty
  a_pll_first: assert property (p_pll_first) else $error("cpu before pll");
  property p_active;
    PLL_EN |-> BUS_CLK_EN && XTAL_EN && SLOW_CLK_EN;
  endproperty
  a_active: assert property (p_active) else $error("pll without bus");
  property p_wake;
    $rose(HOST_WAKE) && SLOW_CLK_EN && !XTAL_EN |-> ##[1:6]
      BUS_CLK_EN && XTAL_EN;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_trig;
    HW_TRIGGER && BUS_CLK_EN && !CPU_CLK_EN |-> ##[1:4]
      PLL_EN && CPU_CLK_SEL_PLL;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger ignored");
  property p_sleep;
    BB_SLEEP_REQ && PLL_EN |-> ##[1:4] SLOW_CLK_EN && !BUS_CLK_EN &&
      !XTAL_EN && !PLL_EN && !CPU_CLK_EN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  c_sleep: cover property (BB_SLEEP_REQ && PLL_EN);
  c_wake: cover property ($rose(HOST_WAKE) && SLOW_CLK_EN && !XTAL_EN);
  c_trig: cover property (HW_TRIGGER && BUS_CLK_EN && !CPU_CLK_EN);
endmodule

bind pmcm_top pmcm_chk u_chk (
  .CORE_CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O,
  .SUPPLY_OK, .SUPPLY_ENABLE_PIN, .HOST_WAKE, .HW_TRIGGER, .BB_SLEEP_REQ,
  .SLOW_CLK_EN, .PLL_EN, .CPU_CLK_EN, .CPU_CLK_SEL_PLL, .BUS_CLK_EN,
  .XTAL_EN
);

// >>> pmcm_host_model.sv
// host side: 32.768 kHz rtc source and wake strobe
// assumes clk is the 20 MHz core clock; rtc phase is unrelated
`timescale 1ns/1ps
module pmcm_host_model (
  // clock
  input  wire logic clk,
  // control from bench
  input  wire logic rtc_on,
  input  wire logic wake_req,
  // pins toward the device
  output logic      rtc_clk,
  output logic      host_wake
);
  initial rtc_clk = 1'b0;
  initial host_wake = 1'b0;
  // held low when absent so probing sees no edges
  always #15258.789 rtc_clk = rtc_on ? ~rtc_clk : 1'b0;
  always @(posedge clk) host_wake <= wake_req;
endmodule

// >>> tb.sv
// self-checking bench for pmcm_top over classic wishbone
// assumes pmcm_host_model supplies rtc clock and wake strobe
`timescale 1ns/1ps
`include "pmcm_defs.svh"
module tb
  import pmcm_pkg::*;
;
  logic        clk, rst, cyc, stb, we, ok, pin, trig, bb, rtc_on, wreq;
  logic        ack, rtc, hwake, irq, xsel, sfd, ssc, s0;
  logic        slow, pll, cpu, csel, bus, xtal;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dat_o, q;
  logic [5:0]  g;
  int          n_mismatch, n_compared, k;
  assign g = {slow, pll, cpu, csel, bus, xtal};
  always #25 clk = ~clk;
  pmcm_host_model host (.clk(clk), .rtc_on(rtc_on), .wake_req(wreq),
    .rtc_clk(rtc), .host_wake(hwake));
  pmcm_top uut (
    .CORE_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SUPPLY_OK(ok),
    .SUPPLY_ENABLE_PIN(pin), .HOST_WAKE(hwake), .HW_TRIGGER(trig),
    .BB_SLEEP_REQ(bb), .RTC_CLK_IN(rtc), .SLOW_CLK_EN(slow),
    .PLL_EN(pll), .CPU_CLK_EN(cpu), .CPU_CLK_SEL_PLL(csel),
    .BUS_CLK_EN(bus), .XTAL_EN(xtal), .XTAL_EXT_SEL(xsel),
    .SLOW_FROM_DIV(sfd), .SLOW_SLEEP_CLOCK(ssc), .IRQ(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) n_mismatch++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic st(input pmcm_state_e s, input logic [5:0] e);
    repeat (6) @(posedge clk);
    chk(32'(g), 32'(e));
    rd(`PMCM_A_STATUS);
    chk(q & 32'h7, 32'(s));
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // budget above metering (13k) plus the 65536-cycle divider probe
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    {clk, rst, cyc, stb, we, trig, bb, wreq} = 8'h40;
    {ok, pin, rtc_on} = 3'h7;
    {adr, sel, wdat} = 44'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    st(PMCM_STANDBY, 6'h2b);
    rd(`PMCM_A_SLEEP_LEN);
    chk(q, `PMCM_SLEEP_RST);
    rd(`PMCM_A_FREQ);
    chk(q & 32'h7, 32'(`PMCM_F_26M));
    rd(8'h20);
    chk(q, 32'h0);
    wb(1'b1, `PMCM_A_SLEEP_LEN, 32'h2, 4'h0);
    rd(`PMCM_A_SLEEP_LEN);
    chk(q, `PMCM_SLEEP_RST);
    $display("test reset and registers done");
    k = 0;
    do begin
      repeat (100) @(posedge clk);
      rd(`PMCM_A_IRQ_STAT);
      k++;
    end while (q[`PMCM_I_FREQ] !== 1'b1 && k < 300);
    chk(q & 32'h4, 32'h4);
    rd(`PMCM_A_METER);
    chk(32'(q >= 32'd9764 && q <= 32'd9767), 32'h1);
    rd(`PMCM_A_FREQ);
    chk(q & 32'h17, 32'h10 | 32'(`PMCM_F_20M));
    wr(`PMCM_A_FREQ, 32'h5);
    rd(`PMCM_A_FREQ);
    chk(q & 32'h17, 32'h10 | 32'(`PMCM_F_20M));
    rd(`PMCM_A_STATUS);
    chk(q & 32'h70, 32'h10);
    chk(32'(sfd), 32'h0);
    s0 = ssc;
    k = 0;
    while (ssc === s0 && k < 700) begin
      @(posedge clk);
      k++;
    end
    chk(32'(ssc !== s0), 32'h1);
    $display("test rtc metering done");
    wr(`PMCM_A_IRQ_EN, 32'h4);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(`PMCM_A_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(`PMCM_A_IRQ_EN, 32'h4);
    wr(`PMCM_A_IRQ_CLR, 32'h4);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd(`PMCM_A_IRQ_STAT);
    chk(q & 32'h4, 32'h0);
    $display("test interrupt done");
    wr(`PMCM_A_CTRL, 32'h8);
    repeat (3) @(posedge clk);
    chk(32'(xsel), 32'h1);
    wr(`PMCM_A_CTRL, 32'h9);
    st(PMCM_ACTIVE, 6'h3f);
    wr(`PMCM_A_CTRL, 32'ha);
    st(PMCM_IDLE, 6'h23);
    trig <= 1'b1;
    st(PMCM_ACTIVE, 6'h3f);
    trig <= 1'b0;
    $display("test modes done");
    bb <= 1'b1;
    st(PMCM_SLEEP, 6'h20);
    bb <= 1'b0;
    wreq <= 1'b1;
    @(posedge clk);
    wreq <= 1'b0;
    st(PMCM_STANDBY, 6'h2b);
    rd(`PMCM_A_IRQ_STAT);
    chk(q & 32'h2, 32'h2);
    // two slow periods is about 1220 core cycles
    wr(`PMCM_A_SLEEP_LEN, 32'h2);
    wr(`PMCM_A_CTRL, 32'h9);
    bb <= 1'b1;
    st(PMCM_SLEEP, 6'h20);
    bb <= 1'b0;
    repeat (400) @(posedge clk);
    st(PMCM_SLEEP, 6'h20);
    repeat (2000) @(posedge clk);
    st(PMCM_STANDBY, 6'h2b);
    $display("test sleep done");
    rtc_on <= 1'b0;
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(g), 32'h0);
    pin <= 1'b1;
    ok <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(g), 32'h0);
    ok <= 1'b1;
    st(PMCM_STANDBY, 6'h2b);
    $display("test supply done");
    // rtc gone: the probe window runs out and the divider takes over
    repeat (66000) @(posedge clk);
    rd(`PMCM_A_STATUS);
    chk(q & 32'h70, 32'h60);
    chk(32'(sfd), 32'h1);
    wr(`PMCM_A_FREQ, 32'h5);
    rd(`PMCM_A_FREQ);
    chk(q & 32'h17, 32'h15);
    s0 = ssc;
    k = 0;
    while (ssc === s0 && k < 700) begin
      @(posedge clk);
      k++;
    end
    chk(32'(ssc !== s0), 32'h1);
    $display("test divider done");
    tally_and_finish();
  end
endmodule
